// ---- hw/uac_pkg.sv ----
// Constants and carrier types for the USB attach, detach and wake control block.
package uac_pkg;

  // ------------------------------------------------------------------
  // Pins and selections
  // ------------------------------------------------------------------
  localparam int          NPIO       = 16;
  localparam int          SEL_W      = 4;
  localparam logic [3:0]  PU_SEL_RST = 4'h0;
  localparam logic [3:0]  VB_SEL_RST = 4'h1;
  localparam logic [3:0]  DT_SEL_RST = 4'h2;
  localparam logic [3:0]  WK_SEL_RST = 4'h3;

  // ------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam int          AW         = 8;
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_PINSEL = 8'h04;
  localparam logic [7:0]  OFS_MAXPWR = 8'h08;
  localparam logic [7:0]  OFS_STATUS = 8'h0c;

  // ------------------------------------------------------------------
  // Control fields
  // ------------------------------------------------------------------
  localparam int          CTRL_READY = 0;
  localparam int          CTRL_SELF  = 1;
  localparam int          CTRL_EXT   = 2;
  localparam int          CTRL_WAKE  = 3;
  localparam logic [3:0]  CTRL_RST   = 4'h0;

  // ------------------------------------------------------------------
  // Pin select fields
  // ------------------------------------------------------------------
  localparam int          PS_PU_LSB  = 0;
  localparam int          PS_VB_LSB  = 8;
  localparam int          PS_DT_LSB  = 16;
  localparam int          PS_WK_LSB  = 24;

  // ------------------------------------------------------------------
  // Maximum power setting, in mA, and its key
  // ------------------------------------------------------------------
  localparam int          MP_W       = 10;
  localparam logic [9:0]  MAXPWR_RST = 10'h12c;
  localparam logic [9:0]  MAXPWR_CAP = 10'h1f4;
  localparam logic [15:0] MAXPWR_KEY = 16'h02c6;
  localparam int          MP_KEY_LSB = 16;

  // ------------------------------------------------------------------
  // Status fields
  // ------------------------------------------------------------------
  localparam int          ST_VBUS    = 0;
  localparam int          ST_DET     = 1;
  localparam int          ST_PULL    = 2;
  localparam int          ST_WAKE    = 3;
  localparam int          ST_LOWP    = 4;
  localparam int          ST_ENUMW   = 5;

  // ------------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic o;
    logic oe;
  } uac_pad_t;

  typedef struct packed {
    logic dp_o;
    logic dn_o;
    logic oe;
  } uac_phy_t;

  typedef enum logic [1:0] {
    UAC_OFF,
    UAC_ON,
    UAC_DETACH
  } uac_state_t;

endpackage

// ---- hw/uac_sync.sv ----
// Two flip-flop synchroniser for a vector of pin inputs.
`timescale 1ns/1ps
module uac_sync
  import uac_pkg::*;
#(
  parameter int W = NPIO
) (
  input  logic         clk_sys,
  input  logic         rst,
  input  logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage feeds only the second stage.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule

// ---- hw/uac_pin_mux.sv ----
// Picks one pin out of a vector by its number; out-of-range numbers give zero.
`timescale 1ns/1ps
module uac_pin_mux
  import uac_pkg::*;
#(
  parameter int N  = NPIO,
  parameter int SW = SEL_W
) (
  input  logic [N-1:0]  pins,
  input  logic [SW-1:0] sel,
  output logic          bit_o
);

  wire in_range = 32'(sel) < N;

  assign bit_o = in_range ? pins[sel] : 1'b0;

endmodule

// ---- hw/uac_ctrl.sv ----
// USB attach, detach, wake and suspend-power control with an APB register slave.
`timescale 1ns/1ps
module uac_ctrl
  import uac_pkg::*;
#(
  parameter int N = NPIO
) (
  input  logic              clk_sys,
  input  logic              rst,
  input  logic              psel,
  input  logic              penable,
  input  logic              pwrite,
  input  logic [AW-1:0]     paddr,
  input  logic [31:0]       pwdata,
  input  logic [3:0]        pstrb,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  logic [N-1:0]      pio_i,
  output logic [N-1:0]      pio_o,
  output logic [N-1:0]      pio_oe,
  input  uac_phy_t          phy,
  output uac_pad_t          plus_data_line,
  output uac_pad_t          minus_data_line,
  output logic              pullup_int_en,
  input  logic              usb_suspend,
  input  logic              usb_configured,
  output logic              radio_en,
  output logic              load_en,
  output logic [7:0]        max_power_desc
);

  // ------------------------------------------------------------------
  // Registers and pin sampling
  // ------------------------------------------------------------------
  logic [3:0]      ctrl_q;
  logic [SEL_W-1:0] pullup_pin_select_q;
  logic [SEL_W-1:0] bus_power_sense_pin_select_q;
  logic [SEL_W-1:0] detach_pin_select_q;
  logic [SEL_W-1:0] wake_pin_select_q;
  logic [MP_W-1:0] max_power_setting_q;
  logic [31:0]     prdata_q;
  uac_state_t      state_q;
  uac_state_t      state_d;
  logic [N-1:0]    pio_o_q;
  logic [N-1:0]    pio_oe_q;
  logic            low_power_q;
  logic [7:0]      desc_q;
  logic [N-1:0]    pio_s;
  logic            vbus_s;
  logic            detach_s;

  uac_sync #(
    .W (N)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       (pio_i),
    .q       (pio_s)
  );

  uac_pin_mux #(
    .N  (N),
    .SW (SEL_W)
  ) u_vbus_mux (
    .pins  (pio_s),
    .sel   (bus_power_sense_pin_select_q),
    .bit_o (vbus_s)
  );

  uac_pin_mux #(
    .N  (N),
    .SW (SEL_W)
  ) u_detach_mux (
    .pins  (pio_s),
    .sel   (detach_pin_select_q),
    .bit_o (detach_s)
  );

  // ------------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------------
  wire         acc      = psel && penable;
  wire         setup    = psel && !penable;
  wire         hit_ctrl = paddr == OFS_CTRL;
  wire         hit_ps   = paddr == OFS_PINSEL;
  wire         hit_mp   = paddr == OFS_MAXPWR;
  wire         hit_st   = paddr == OFS_STATUS;
  wire         hit      = hit_ctrl || hit_ps || hit_mp || hit_st;
  wire         wr       = acc && pwrite && hit;
  wire [31:0]  bmask    = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  wire         ready_b  = ctrl_q[CTRL_READY];
  wire         self_b   = ctrl_q[CTRL_SELF];
  wire         ext_b    = ctrl_q[CTRL_EXT];
  wire         wake_b   = ctrl_q[CTRL_WAKE];

  wire [31:0]  ctrl_rd  = {28'h0000000, ctrl_q};
  wire [31:0]  ps_rd    = {{(8 - SEL_W){1'b0}}, wake_pin_select_q,
                           {(8 - SEL_W){1'b0}}, detach_pin_select_q,
                           {(8 - SEL_W){1'b0}}, bus_power_sense_pin_select_q,
                           {(8 - SEL_W){1'b0}}, pullup_pin_select_q};
  wire [31:0]  mp_rd    = {MAXPWR_KEY, {(MP_KEY_LSB - MP_W){1'b0}}, max_power_setting_q};

  // ------------------------------------------------------------------
  // Connection state
  // ------------------------------------------------------------------
  wire         vbus_ok  = !self_b || vbus_s;
  wire         can_att  = ready_b && vbus_ok;
  wire         attached = state_q == UAC_ON;
  wire         detached = state_q == UAC_DETACH;
  wire         wake_on  = detached && wake_b;
  wire         enum_wait = attached && !usb_configured;

  wire [31:0]  st_rd    = {26'h0, enum_wait, low_power_q, wake_on,
                           attached, detach_s, vbus_s};
  wire [31:0]  rd_mux   = hit_ctrl ? ctrl_rd :
                          hit_ps   ? ps_rd   :
                          hit_mp   ? mp_rd   :
                          hit_st   ? st_rd   : 32'h00000000;

  wire [31:0]  ctrl_nw  = (ctrl_rd & ~bmask) | (pwdata & bmask);
  wire [31:0]  ps_nw    = (ps_rd & ~bmask) | (pwdata & bmask);
  wire [31:0]  mp_nw    = (mp_rd & ~bmask) | (pwdata & bmask);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      UAC_OFF: begin
        if (detach_s) begin
          state_d = UAC_DETACH;
        end else if (can_att) begin
          state_d = UAC_ON;
        end
      end
      UAC_ON: begin
        if (detach_s) begin
          state_d = UAC_DETACH;
        end else if (!can_att) begin
          state_d = UAC_OFF;
        end
      end
      UAC_DETACH: begin
        if (!detach_s) begin
          state_d = can_att ? UAC_ON : UAC_OFF;
        end
      end
    endcase
  end

  // ------------------------------------------------------------------
  // Pads, pins and power
  // ------------------------------------------------------------------
  wire         ext_pull = attached && ext_b;
  wire [N-1:0] pio_o_d;
  wire [N-1:0] pio_oe_d;

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_pio
      wire is_pu = ext_b && (32'(pullup_pin_select_q) == gi);
      wire is_wk = 32'(wake_pin_select_q) == gi;
      // The pull-up pin floats when disconnected; the wake pin always drives, except when it is also the pull-up pin with the external pull-up on.
      assign pio_o_d[gi]  = is_pu ? ext_pull : (is_wk && wake_on);
      assign pio_oe_d[gi] = is_pu ? ext_pull : is_wk;
    end
  endgenerate

  wire         lowp_d   = usb_suspend && !self_b;
  wire [MP_W-1:0] mp_half = MP_W'(max_power_setting_q >> 1);
  wire [MP_W-1:0] cap_half = MP_W'(MAXPWR_CAP >> 1);
  wire [7:0]   desc_d   = (max_power_setting_q > MAXPWR_CAP) ? cap_half[7:0]
                                                             : mp_half[7:0];

  // Only the plus line may carry a pull-up: a full-speed device.
  assign pullup_int_en         = attached && !ext_b;
  assign plus_data_line.o      = phy.dp_o;
  assign plus_data_line.oe     = phy.oe && attached;
  assign minus_data_line.o     = phy.dn_o;
  assign minus_data_line.oe    = phy.oe && attached;
  assign pio_o                 = pio_o_q;
  assign pio_oe                = pio_oe_q;
  assign radio_en              = !low_power_q;
  assign load_en               = !low_power_q;
  assign max_power_desc        = desc_q;
  assign prdata                = prdata_q;
  assign pready                = 1'b1;
  assign pslverr               = acc && !hit;

  // ------------------------------------------------------------------
  // Sequential logic
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
      pullup_pin_select_q          <= PU_SEL_RST;
      bus_power_sense_pin_select_q <= VB_SEL_RST;
      detach_pin_select_q          <= DT_SEL_RST;
      wake_pin_select_q            <= WK_SEL_RST;
      max_power_setting_q          <= MAXPWR_RST;
    end else begin
      if (wr && hit_ctrl) begin
        ctrl_q <= ctrl_nw[3:0];
      end
      if (wr && hit_ps) begin
        pullup_pin_select_q          <= ps_nw[PS_PU_LSB +: SEL_W];
        bus_power_sense_pin_select_q <= ps_nw[PS_VB_LSB +: SEL_W];
        detach_pin_select_q          <= ps_nw[PS_DT_LSB +: SEL_W];
        wake_pin_select_q            <= ps_nw[PS_WK_LSB +: SEL_W];
      end
      if (wr && hit_mp) begin
        max_power_setting_q <= mp_nw[MP_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q     <= UAC_OFF;
      pio_o_q     <= '0;
      pio_oe_q    <= '0;
      low_power_q <= 1'b0;
      desc_q      <= MAXPWR_RST[8:1];
      prdata_q    <= 32'h00000000;
    end else begin
      state_q     <= state_d;
      pio_o_q     <= pio_o_d;
      pio_oe_q    <= pio_oe_d;
      low_power_q <= lowp_d;
      desc_q      <= desc_d;
      prdata_q    <= setup ? rd_mux : prdata_q;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  wire pull_any = pullup_int_en || ext_pull;

  property p_detach_float;
    @(posedge clk_sys) disable iff (rst)
      detach_s |=> !plus_data_line.oe && !minus_data_line.oe && !pull_any;
  endproperty
  a_detach_float: assert property (p_detach_float)
    else $error("Data lines or pull-up active while detach is high.");

  property p_no_vbus;
    @(posedge clk_sys) disable iff (rst)
      (self_b && !vbus_s) |=> !pull_any;
  endproperty
  a_no_vbus: assert property (p_no_vbus)
    else $error("Pull-up on without bus power in self-powered mode.");

  property p_not_ready;
    @(posedge clk_sys) disable iff (rst)
      !ready_b |=> !pull_any;
  endproperty
  a_not_ready: assert property (p_not_ready)
    else $error("Pull-up on before the device is ready.");

  property p_reconnect;
    @(posedge clk_sys) disable iff (rst)
      (detached && !detach_s && can_att) |=> pull_any ##0 enum_wait == !usb_configured;
  endproperty
  a_reconnect: assert property (p_reconnect)
    else $error("Device did not reconnect after detach fell.");

  property p_wake_only_detached;
    @(posedge clk_sys) disable iff (rst)
      pio_o_q[wake_pin_select_q] && !ext_b |-> $past(state_q) == UAC_DETACH;
  endproperty
  a_wake_only_detached: assert property (p_wake_only_detached)
    else $error("Wake output high while not detached.");

  property p_wake_drive;
    @(posedge clk_sys) disable iff (rst)
      (wake_on && !ext_b) |=> $stable(wake_pin_select_q) |->
        pio_o_q[wake_pin_select_q] && pio_oe_q[wake_pin_select_q];
  endproperty
  a_wake_drive: assert property (p_wake_drive)
    else $error("Wake request not driven onto its pin.");

  property p_int_default;
    @(posedge clk_sys)
      $past(rst) && !rst |-> !ext_b && !pio_oe_q[pullup_pin_select_q];
  endproperty
  a_int_default: assert property (p_int_default)
    else $error("External pull-up selected after reset.");

  property p_suspend_off;
    @(posedge clk_sys) disable iff (rst)
      (usb_suspend && !self_b) |=> !radio_en && !load_en;
  endproperty
  a_suspend_off: assert property (p_suspend_off)
    else $error("Radio or loads on during bus-powered suspend.");

  property p_maxpwr;
    @(posedge clk_sys) disable iff (rst)
      (max_power_setting_q == MAXPWR_RST && $stable(max_power_setting_q)) |=>
        max_power_desc == 8'h96;
  endproperty
  a_maxpwr: assert property (p_maxpwr)
    else $error("Power descriptor does not match 300 mA setting.");

  property p_full_speed_only;
    @(posedge clk_sys) disable iff (rst)
      pullup_int_en |-> attached && !ext_b && !minus_data_line.oe == !phy.oe;
  endproperty
  a_full_speed_only: assert property (p_full_speed_only)
    else $error("Pull-up state inconsistent with full-speed peripheral.");

  property p_ext_pin;
    @(posedge clk_sys) disable iff (rst)
      ext_pull |=> $stable(pullup_pin_select_q) |->
        pio_o_q[pullup_pin_select_q] && pio_oe_q[pullup_pin_select_q];
  endproperty
  a_ext_pin: assert property (p_ext_pin)
    else $error("External pull-up pin not driven high while attached.");

  property p_reconnect_blocked;
    @(posedge clk_sys) disable iff (rst)
      (detached && !detach_s && !can_att) |=> !pull_any && !plus_data_line.oe;
  endproperty
  a_reconnect_blocked: assert property (p_reconnect_blocked)
    else $error("Reconnected after detach without bus power or readiness.");

  property p_wake_idle;
    @(posedge clk_sys) disable iff (rst)
      (!wake_on && !ext_b) |=> $stable(wake_pin_select_q) |->
        !pio_o_q[wake_pin_select_q] && pio_oe_q[wake_pin_select_q];
  endproperty
  a_wake_idle: assert property (p_wake_idle)
    else $error("Wake pin not driven low while wake is inactive.");

  property p_radio_back;
    @(posedge clk_sys) disable iff (rst)
      !(usb_suspend && !self_b) |=> radio_en && load_en;
  endproperty
  a_radio_back: assert property (p_radio_back)
    else $error("Radio or loads left off outside bus-powered suspend.");

endmodule

// ---- bench/uac_host_model.sv ----
// Behavioural host-side model that senses the plus data line and drives the detach pin.
`timescale 1ns/1ps
module uac_host_model
  import uac_pkg::*;
#(
  parameter int PU_PIN = 0
) (
  input  uac_pad_t         plus_data_line,
  input  logic             pullup_int_en,
  input  logic [NPIO-1:0]  pio_o,
  input  logic [NPIO-1:0]  pio_oe,
  input  logic             detach_req,
  input  logic [SEL_W-1:0] det_sel,
  output logic             dp_level,
  output logic             attached,
  output logic [NPIO-1:0]  det_pins
);
  wire ext_pu = pio_oe[PU_PIN] & pio_o[PU_PIN];
  // The host pull-down holds the line low unless the pad or a pull-up lifts it.
  assign dp_level = plus_data_line.oe ? plus_data_line.o : (pullup_int_en | ext_pu);
  assign attached = ~plus_data_line.oe & dp_level;
  // External logic raises the detach request on the selected pin.
  assign det_pins = detach_req ? (NPIO'(1) << det_sel) : '0;
endmodule

// ---- bench/uac_ctrl_tb.sv ----
// Self-checking testbench for the USB attach, detach and wake control block.
`timescale 1ns/1ps
module uac_ctrl_tb
  import uac_pkg::*;
;
  logic            clk_sys, rst, psel, penable, pwrite, pready, pslverr, err_q;
  logic [AW-1:0]   paddr;
  logic [31:0]     pwdata, prdata, rd;
  logic [3:0]      pstrb;
  logic [NPIO-1:0] pio_i, pio_o, pio_oe, tb_pins, det_pins;
  uac_phy_t        phy;
  uac_pad_t        dp_pad, dn_pad;
  logic            pullup_int_en, usb_suspend, usb_configured, radio_en, load_en;
  logic [7:0]      max_power_desc;
  logic            detach_req, dp_level, attached;
  logic [3:0]      det_sel;
  int              num_errors, n_compared;

  assign pio_i = tb_pins | det_pins;

  uac_ctrl u_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pio_i(pio_i), .pio_o(pio_o), .pio_oe(pio_oe),
    .phy(phy), .plus_data_line(dp_pad), .minus_data_line(dn_pad),
    .pullup_int_en(pullup_int_en), .usb_suspend(usb_suspend),
    .usb_configured(usb_configured), .radio_en(radio_en), .load_en(load_en),
    .max_power_desc(max_power_desc));

  uac_host_model u_host (.plus_data_line(dp_pad), .pullup_int_en(pullup_int_en),
    .pio_o(pio_o), .pio_oe(pio_oe), .detach_req(detach_req), .det_sel(det_sel),
    .dp_level(dp_level), .attached(attached), .det_pins(det_pins));

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Clock and watchdog
  // ------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  initial begin
    #(40 * 5000);
    num_errors++;
    give_verdict();
  end

  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    pstrb = 4'hf; tb_pins = '0; phy = '0; usb_suspend = 1'b0; usb_configured = 1'b0;
    detach_req = 1'b0; det_sel = DT_SEL_RST; num_errors = 0; n_compared = 0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    apb(0, OFS_MAXPWR, 0);
    chk(rd, {MAXPWR_KEY, 6'h00, MAXPWR_RST});
    chk(max_power_desc, 8'h96);
    apb(0, OFS_PINSEL, 0);
    chk(rd, {4'h0, WK_SEL_RST, 4'h0, DT_SEL_RST, 4'h0, VB_SEL_RST, 4'h0, PU_SEL_RST});
    apb(0, OFS_CTRL, 0);
    chk(rd, 32'h0);
    chk(pullup_int_en, 1'b0);
    chk(attached, 1'b0);
    apb(0, 8'h10, 0);
    chk(err_q, 1'b1);
    chk(rd, 32'h0);
    $display("test reset done");
    apb(1, OFS_CTRL, 32'h1);
    cyc(4);
    chk(pullup_int_en, 1'b1);
    chk(attached, 1'b1);
    apb(1, OFS_CTRL, 32'h3);
    cyc(5);
    chk(pullup_int_en, 1'b0);
    tb_pins[1] <= 1'b1;
    cyc(5);
    chk(pullup_int_en, 1'b1);
    apb(1, OFS_PINSEL, 32'h03020500);
    cyc(5);
    chk(pullup_int_en, 1'b0);
    tb_pins[5] <= 1'b1;
    cyc(5);
    chk(pullup_int_en, 1'b1);
    $display("test attach done");
    phy <= '{dp_o: 1'b1, dn_o: 1'b0, oe: 1'b1};
    apb(1, OFS_CTRL, 32'h9);
    cyc(5);
    chk({dp_pad.oe, dn_pad.oe, dp_pad.o, dn_pad.o}, 4'he);
    chk({pio_oe[3], pio_o[3]}, 2'h2);
    detach_req <= 1'b1;
    cyc(5);
    chk({dp_pad.oe, dn_pad.oe, pullup_int_en}, 3'h0);
    chk({pio_oe[3], pio_o[3]}, 2'h3);
    detach_req <= 1'b0;
    cyc(5);
    chk({dp_pad.oe, pullup_int_en, pio_o[3]}, 3'h6);
    apb(1, OFS_PINSEL, 32'h09070500);
    det_sel <= 4'h7;
    detach_req <= 1'b1;
    cyc(5);
    chk({pullup_int_en, pio_o[9]}, 2'h1);
    apb(0, OFS_STATUS, 0);
    chk(rd, 32'h0000000b);
    detach_req <= 1'b0;
    cyc(5);
    chk(pullup_int_en, 1'b1);
    apb(0, OFS_STATUS, 0);
    chk(rd, 32'h00000025);
    usb_configured <= 1'b1;
    apb(0, OFS_STATUS, 0);
    chk(rd, 32'h00000005);
    $display("test detach done");
    phy <= '0;
    apb(1, OFS_CTRL, 32'h5);
    cyc(5);
    chk({pullup_int_en, pio_oe[0], pio_o[0], attached}, 4'h7);
    apb(1, OFS_CTRL, 32'h1);
    usb_suspend <= 1'b1;
    cyc(3);
    chk({radio_en, load_en}, 2'h0);
    apb(1, OFS_CTRL, 32'h3);
    cyc(3);
    chk({radio_en, load_en}, 2'h3);
    usb_suspend <= 1'b0;
    $display("test power done");
    apb(1, OFS_MAXPWR, 32'hffff00c8);
    cyc(3);
    chk(max_power_desc, 8'h64);
    apb(0, OFS_MAXPWR, 0);
    chk(rd, {MAXPWR_KEY, 6'h00, 10'h0c8});
    pstrb <= 4'h2;
    apb(1, OFS_MAXPWR, 32'h00000100);
    pstrb <= 4'hf;
    cyc(3);
    chk(max_power_desc, 8'he4);
    apb(1, OFS_MAXPWR, 32'h00000258);
    cyc(3);
    chk(max_power_desc, 8'hfa);
    $display("test max power done");
    give_verdict();
  end
endmodule
